// ==== lin_status_pkg.sv ====
package lin_status_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h08;
    localparam logic [5:0] IDX_STAT = 6'h09;
    localparam logic [5:0] IDX_ERR = 6'h0A;
    localparam logic [5:0] IDX_MODE = 6'h0F;
    // Control bit positions
    localparam int CTRL_STOP = 7;
    localparam int CTRL_ACK = 4;
    localparam int CTRL_INTERRUPT_CLEAR_CMD = 3;
    localparam int CTRL_ERROR_CLEAR_CMD = 2;
    // Mode bit position (1 = slave)
    localparam int MODE_SLAVE = 0;
    // Reset values
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic MODE_RESET = 1'b0;
    // Timing
    localparam longint CLK_HZ = 40000000;
    localparam longint IDLE_TIME_S = 4;
    localparam longint IDLE_CYC = IDLE_TIME_S * CLK_HZ;
    localparam longint FRAME_MAX_US = 10000;
    localparam longint FRAME_CYC = FRAME_MAX_US * CLK_HZ / 1000000;
    localparam int CNT_W = 28;
    // Status register layout, bit 7 first
    typedef struct packed {
        logic active;
        logic idle_timeout_error_flag;
        logic abort;
        logic data_request_flag;
        logic int_pend;
        logic error;
        logic wakeup;
        logic done;
    } status_type;
    // Error register layout, bit 7 first
    typedef struct packed {
        logic [2:0] unused;
        logic sync_err;
        logic parity;
        logic timeout_error_flag;
        logic chk;
        logic bit_err;
    } errors_type;
endpackage

// ==== lin_status_regs.sv ====
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
// How it works
// - Bit 7 follows bus activity
// - Slave: flag four seconds idle unless asleep
// - Slave: abort on early break or stop
// - Clean sync break clears abort
// - Slave: data request on data identifier
// - Interrupt pending held, cleared by command
// - Error flag set, cleared by command
// - Wakeup flag while sending or received
// - Done cleared at start, set at end
// - Status 0x09, errors 0x0A, read-only
// - Error bits 7:5 read zero
// - Slave: sync field tolerance error
// - Slave: identifier parity error
// - Master: missing slave response is timeout
// - Slave: missing data is timeout
// - Overlong frame is timeout
// - Ack or stop due before first byte
// - Checksum mismatch error
// - Sent versus monitored bit mismatch
// - Error clear wipes error register and status error flag
// - Slave stop blocks until sync break
// - Data ack clears itself
module lin_status_regs #(
    parameter longint IDLE_CYCLES = lin_status_pkg::IDLE_CYC,
    parameter longint FRAME_CYCLES = lin_status_pkg::FRAME_CYC
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic BUS_ACTIVE,
    input wire logic BUS_SLEEP,
    input wire logic SYNC_BREAK,
    input wire logic FRAME_START,
    input wire logic FRAME_DONE,
    input wire logic ID_DATA,
    input wire logic FIRST_BYTE_DONE,
    input wire logic SYNC_TOL_ERR,
    input wire logic ID_PARITY_ERR,
    input wire logic RESP_MISSING,
    input wire logic DATA_MISSING,
    input wire logic CHECKSUM_ERR,
    input wire logic BIT_CHECK,
    input wire logic TX_BIT,
    input wire logic RX_BIT,
    input wire logic WAKEUP_TX,
    input wire logic WAKEUP_RX,
    output logic DATA_ACK,
    output logic BLOCKED
);
    // Flag registers
    lin_status_pkg::status_type st_r;
    lin_status_pkg::errors_type err_r;
    // Software settings, commands and internal frame state
    logic slave_r;
    logic data_ack_r;
    logic blocked_r;
    logic frame_busy_r;
    logic await_ack_r;
    logic wake_rx_r;
    logic [31:0] prdata_r;
    // Timers
    logic [lin_status_pkg::CNT_W-1:0] idle_cnt_r;
    logic [lin_status_pkg::CNT_W-1:0] frame_cnt_r;
    // Decoded bus strobes
    logic wr_acc;
    logic [5:0] idx;
    logic hit;
    logic wr_ctrl;
    logic stop_wr;
    logic ack_wr;
    logic interrupt_clear_cmd_wr;
    logic error_clear_cmd_wr;
    // Events after stop blocking
    logic id_evt;
    logic done_evt;
    // Error set terms
    logic set_sync;
    logic set_par;
    logic set_timeout_error_flag;
    logic set_chk;
    logic set_bit;
    logic any_err_set;
    logic any_int_set;
    logic frame_over;
    logic idle_hit;
    logic [7:0] stat_view;

    // Bus decode; address bits 1:0 are ignored
    assign idx = PADDR[7:2];
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign hit = (idx == lin_status_pkg::IDX_CTRL) || (idx == lin_status_pkg::IDX_STAT)
        || (idx == lin_status_pkg::IDX_ERR) || (idx == lin_status_pkg::IDX_MODE);
    assign wr_ctrl = wr_acc && (idx == lin_status_pkg::IDX_CTRL);
    assign stop_wr = wr_ctrl && PWDATA[lin_status_pkg::CTRL_STOP] && slave_r;
    assign ack_wr = wr_ctrl && PWDATA[lin_status_pkg::CTRL_ACK];
    assign interrupt_clear_cmd_wr = wr_ctrl && PWDATA[lin_status_pkg::CTRL_INTERRUPT_CLEAR_CMD];
    assign error_clear_cmd_wr = wr_ctrl && PWDATA[lin_status_pkg::CTRL_ERROR_CLEAR_CMD];
    // Zero wait states
    assign PREADY = 1'b1;
    // Unmapped words answer with an error
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign PRDATA = prdata_r;
    assign DATA_ACK = data_ack_r;
    assign BLOCKED = blocked_r;

    // a blocked slave ignores frame events
    assign id_evt = ID_DATA && slave_r && !blocked_r;
    assign done_evt = FRAME_DONE && !blocked_r;
    assign frame_over = frame_busy_r
        && (frame_cnt_r == lin_status_pkg::CNT_W'(FRAME_CYCLES - 1));
    assign idle_hit = idle_cnt_r == lin_status_pkg::CNT_W'(IDLE_CYCLES - 1);

    // Error detection terms
    // sync tolerance, slave only
    assign set_sync = SYNC_TOL_ERR && slave_r && !blocked_r;
    assign set_par = ID_PARITY_ERR && slave_r && !blocked_r;
    assign set_timeout_error_flag = (RESP_MISSING && !slave_r) || (DATA_MISSING && slave_r)
        || frame_over || (FIRST_BYTE_DONE && await_ack_r && !ack_wr && !stop_wr);
    assign set_chk = CHECKSUM_ERR && !blocked_r;
    // monitored bit differs from sent bit
    assign set_bit = BIT_CHECK && (TX_BIT != RX_BIT);
    assign any_err_set = set_sync || set_par || set_timeout_error_flag || set_chk || set_bit;
    // events that raise the pending flag
    assign any_int_set = done_evt || id_evt || WAKEUP_RX || any_err_set;

    // Read view; the status flags as stored, bit 2 driven from the error flag
    always_comb begin
        stat_view = st_r;
        stat_view[2] = st_r.error;
    end

    // Mode register, written by software
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            slave_r <= lin_status_pkg::MODE_RESET;
        end else if (wr_acc && idx == lin_status_pkg::IDX_MODE) begin
            slave_r <= PWDATA[lin_status_pkg::MODE_SLAVE];
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            prdata_r <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            prdata_r <= 32'h00000000;
            case (idx)
                // Control: only data ack reads back
                lin_status_pkg::IDX_CTRL: begin
                    prdata_r[lin_status_pkg::CTRL_ACK] <= data_ack_r;
                end
                lin_status_pkg::IDX_STAT: begin
                    prdata_r[7:0] <= stat_view;
                end
                lin_status_pkg::IDX_ERR: begin
                    prdata_r[7:0] <= {3'h0, err_r[4:0]};
                end
                lin_status_pkg::IDX_MODE: begin
                    prdata_r[0] <= slave_r;
                end
                // Unmapped reads return zero
                default: begin
                    prdata_r <= 32'h00000000;
                end
            endcase
        end
    end

    // data ack is a one-cycle command
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            data_ack_r <= 1'b0;
        end else begin
            data_ack_r <= ack_wr && slave_r;
        end
    end

    // stop blocks until next sync break
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            blocked_r <= 1'b0;
        end else if (stop_wr) begin
            blocked_r <= 1'b1;
        end else if (SYNC_BREAK) begin
            blocked_r <= 1'b0;
        end
    end

    // Frame in flight, from break or start to done
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            frame_busy_r <= 1'b0;
        end else if (SYNC_BREAK || FRAME_START) begin
            frame_busy_r <= 1'b1;
        end else if (FRAME_DONE || frame_over || stop_wr) begin
            frame_busy_r <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            frame_cnt_r <= '0;
        end else if (!frame_busy_r || SYNC_BREAK || FRAME_START) begin
            frame_cnt_r <= '0;
        end else begin
            frame_cnt_r <= frame_cnt_r + 1'b1;
        end
    end

    // window for ack or stop after identifier
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            await_ack_r <= 1'b0;
        end else if (id_evt) begin
            await_ack_r <= 1'b1;
        end else if (ack_wr || stop_wr || FIRST_BYTE_DONE || SYNC_BREAK) begin
            await_ack_r <= 1'b0;
        end
    end

    // idle timer, restarted by any activity
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            idle_cnt_r <= '0;
        end else if (BUS_ACTIVE || !slave_r || BUS_SLEEP) begin
            idle_cnt_r <= '0;
        end else if (!idle_hit) begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r.active <= 1'b0;
        end else begin
            st_r.active <= BUS_ACTIVE;
        end
    end

    // idle flag, dropped by activity or sleep
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r.idle_timeout_error_flag <= 1'b0;
        end else begin
            st_r.idle_timeout_error_flag <= idle_hit && slave_r && !BUS_SLEEP && !BUS_ACTIVE;
        end
    end

    // Abort: set wins over the clean-break clear
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r.abort <= 1'b0;
        end else if (slave_r && (stop_wr || (SYNC_BREAK && frame_busy_r))) begin
            st_r.abort <= 1'b1;
        end else if (SYNC_BREAK) begin
            st_r.abort <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r.data_request_flag <= 1'b0;
        end else if (id_evt) begin
            st_r.data_request_flag <= 1'b1;
        end else if (!slave_r || ack_wr || stop_wr || SYNC_BREAK) begin
            st_r.data_request_flag <= 1'b0;
        end
    end

    // pending flag; a new event beats the clear
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r.int_pend <= 1'b0;
        end else if (any_int_set) begin
            st_r.int_pend <= 1'b1;
        end else if (interrupt_clear_cmd_wr) begin
            st_r.int_pend <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r.error <= 1'b0;
        end else if (any_err_set) begin
            st_r.error <= 1'b1;
        end else if (error_clear_cmd_wr) begin
            st_r.error <= 1'b0;
        end
    end

    // received wakeup is held until next frame
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            wake_rx_r <= 1'b0;
        end else if (WAKEUP_RX) begin
            wake_rx_r <= 1'b1;
        end else if (SYNC_BREAK || FRAME_START) begin
            wake_rx_r <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r.wakeup <= 1'b0;
        end else begin
            st_r.wakeup <= WAKEUP_TX || WAKEUP_RX || wake_rx_r;
        end
    end

    // done flag; start of a frame wins
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r.done <= 1'b0;
        end else if (FRAME_START) begin
            st_r.done <= 1'b0;
        end else if (done_evt) begin
            st_r.done <= 1'b1;
        end
    end

    // Error word; each set beats a same-cycle clear
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            err_r <= lin_status_pkg::ERR_RESET;
        end else begin
            // clear all, then re-apply fresh sets
            if (error_clear_cmd_wr) begin
                err_r <= lin_status_pkg::ERR_RESET;
            end
            if (set_sync) begin
                err_r.sync_err <= 1'b1;
            end
            if (set_par) begin
                err_r.parity <= 1'b1;
            end
            if (set_timeout_error_flag) begin
                err_r.timeout_error_flag <= 1'b1;
            end
            if (set_chk) begin
                err_r.chk <= 1'b1;
            end
            if (set_bit) begin
                err_r.bit_err <= 1'b1;
            end
            err_r.unused <= 3'h0;
        end
    end

    // Checks on flag behaviour
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    active_follows_a: assert property (BUS_ACTIVE |=> st_r.active)
        else $error("activity flag missed bus activity");
    idle_clear_a: assert property (BUS_ACTIVE |=> !st_r.idle_timeout_error_flag)
        else $error("idle flag stayed up during activity");
    abort_set_a: assert property (
        slave_r && SYNC_BREAK && frame_busy_r |=> st_r.abort)
        else $error("early break did not abort");
    abort_clear_a: assert property (
        SYNC_BREAK && !frame_busy_r && !stop_wr |=> !st_r.abort)
        else $error("clean break left abort set");
    data_request_flag_set_a: assert property (id_evt |=> st_r.data_request_flag)
        else $error("data request not raised");
    int_clear_a: assert property (
        interrupt_clear_cmd_wr && !any_int_set |=> !st_r.int_pend)
        else $error("pending flag not cleared");
    err_wipe_a: assert property (
        error_clear_cmd_wr && !any_err_set |=> err_r == 8'h00 && !st_r.error)
        else $error("error clear left bits set");
    done_seq_a: assert property (
        FRAME_START ##1 (!FRAME_DONE && !FRAME_START) |-> !st_r.done ##1 !st_r.done)
        else $error("done not cleared at start");
    bit_err_a: assert property (
        BIT_CHECK && TX_BIT != RX_BIT |=> err_r.bit_err && st_r.error)
        else $error("bit mismatch not flagged");
    ack_late_a: assert property (
        await_ack_r && FIRST_BYTE_DONE && !ack_wr && !stop_wr |=> err_r.timeout_error_flag)
        else $error("missing ack not timed out");
    ack_pulse_a: assert property (data_ack_r |=> !data_ack_r)
        else $error("data ack did not self clear");
    err_consist_a: assert property ((|err_r[4:0]) |-> st_r.error)
        else $error("error status out of step");
    high_zero_a: assert property (err_r[7:5] == 3'h0)
        else $error("unused error bits set");
    block_hold_a: assert property (
        blocked_r && !SYNC_BREAK |=> blocked_r)
        else $error("stop released without break");
endmodule

// ==== lin_node_model.sv ====
`timescale 1ns/1ps
// Stand-in for the frame engine and far-side nodes: one pulse per request
module lin_node_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic req,
    input wire logic [3:0] code,
    output logic [10:0] evt,
    output logic bit_check,
    output logic tx_bit,
    output logic rx_bit
);
    // Event pulses last one cycle, never held
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            evt <= 11'h000;
            bit_check <= 1'b0;
        end else begin
            evt <= 11'h000;
            // Codes above ten are bit checks, not events
            if (req && code < 4'hB) begin
                evt[code] <= 1'b1;
            end
            bit_check <= req && (code > 4'hA);
        end
    end

    // Sent bit toggles every cycle so a stale value never matches by luck
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_bit <= 1'b0;
            rx_bit <= 1'b1;
        end else begin
            tx_bit <= ~tx_bit;
            // bad check echoes the inverse of the sent bit
            rx_bit <= (req && code == 4'hC) ? tx_bit : ~tx_bit;
        end
    end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    localparam logic [5:0] C_IX = lin_status_pkg::IDX_CTRL;
    localparam logic [5:0] S_IX = lin_status_pkg::IDX_STAT;
    localparam logic [5:0] E_IX = lin_status_pkg::IDX_ERR;
    localparam logic [5:0] M_IX = lin_status_pkg::IDX_MODE;
    logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic BUS_ACTIVE, BUS_SLEEP, WAKEUP_TX, DATA_ACK, BLOCKED;
    logic req, bchk, txb, rxb;
    logic [3:0] code;
    logic [10:0] evt;
    int n_errors, n_compared, n_ack;

    // Free-running system clock
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    // Short idle and frame limits keep the run brief
    lin_status_regs #(.IDLE_CYCLES(50), .FRAME_CYCLES(100)) u_lin_status_regs (
        .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .BUS_ACTIVE(BUS_ACTIVE), .BUS_SLEEP(BUS_SLEEP),
        .SYNC_BREAK(evt[0]), .FRAME_START(evt[1]), .FRAME_DONE(evt[2]),
        .ID_DATA(evt[3]), .FIRST_BYTE_DONE(evt[4]), .SYNC_TOL_ERR(evt[5]),
        .ID_PARITY_ERR(evt[6]), .RESP_MISSING(evt[7]), .DATA_MISSING(evt[8]),
        .CHECKSUM_ERR(evt[9]), .BIT_CHECK(bchk), .TX_BIT(txb), .RX_BIT(rxb),
        .WAKEUP_TX(WAKEUP_TX), .WAKEUP_RX(evt[10]), .DATA_ACK(DATA_ACK),
        .BLOCKED(BLOCKED)
    );

    lin_node_model u_lin_node_model (
        .clock(CLOCK), .rst(RST), .req(req), .code(code), .evt(evt),
        .bit_check(bchk), .tx_bit(txb), .rx_bit(rxb)
    );

    // Counts acknowledge pulse cycles, catching pulses that stretch
    always @(posedge CLOCK) if (DATA_ACK === 1'b1) n_ack++;

    // Error register bit expected for each event code
    function automatic logic [7:0] errbit(input int c);
        case (c)
            5: return 8'h10;
            6: return 8'h08;
            7, 8: return 8'h04;
            9: return 8'h02;
            12: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction

    task chk(input string name, input logic [7:0] mask, input logic [7:0] exp,
             input logic [7:0] got);
        n_compared++;
        if ((got & mask) !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got & mask);
        end
    endtask

    // One APB transfer; entered just after a rising edge, leaves one idle cycle
    task apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= {idx, 2'b00};
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rd = PRDATA;
        err = PSLVERR;
        if (n >= 50) n_errors++;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask

    task wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    // Read a register and compare the masked byte
    task rc(input logic [5:0] idx, input string name, input logic [7:0] mask,
            input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h00000000, r, e);
        chk(name, mask, exp, r[7:0]);
        chk("mapped slverr", 8'h01, 8'h00, {7'h00, e});
    endtask

    // Clear both interrupt and error state
    task clr;
        wr(C_IX, 32'h0000000C);
    endtask

    // Ask the far side for one event; flag is readable when this returns
    task ev(input int c);
        req <= 1'b1;
        code <= 4'(c);
        @(posedge CLOCK);
        req <= 1'b0;
        repeat (2) @(posedge CLOCK);
    endtask

    task report_and_stop;
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog, well above the expected run of about five hundred and thirty cycles
    initial begin
        repeat (5000) @(posedge CLOCK);
        n_errors++;
        report_and_stop;
    end

    initial begin
        int c;
        int ack0;
        logic [31:0] r;
        logic e;
        static int pick [6] = '{5, 6, 8, 9, 11, 12};
        RST = 1'b1;
        {PSEL, PENABLE, PWRITE, BUS_ACTIVE, BUS_SLEEP, WAKEUP_TX, req} = 7'h00;
        PADDR = 8'h00;
        PWDATA = 32'h00000000;
        code = 4'h0;
        void'($urandom(68));
        repeat (8) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        // Reset values, read-only words, unmapped place
        rc(S_IX, "status reset", 8'hFF, 8'h00);
        rc(E_IX, "error reset", 8'hFF, 8'h00);
        wr(S_IX, $urandom());
        wr(E_IX, $urandom() | 32'h000000E0);
        rc(S_IX, "status write", 8'hFF, 8'h00);
        rc(E_IX, "error write", 8'hFF, 8'h00);
        apb(1'b0, 6'h3E, 32'h00000000, r, e);
        chk("unmapped slverr", 8'h01, 8'h01, {7'h00, e});
        chk("unmapped read", 8'hFF, 8'h00, r[7:0]);
        BUS_ACTIVE <= 1'b1;
        wr(M_IX, 32'h00000001);
        rc(S_IX, "active", 8'h80, 8'h80);
        // Every slave error source, then random repeats
        for (int i = 0; i < 14; i++) begin
            c = (i < 6) ? pick[i] : pick[$urandom_range(5)];
            clr;
            ev(c);
            rc(E_IX, "error bits", 8'hFF, errbit(c));
            rc(S_IX, "error status", 8'h0C, (errbit(c) != 8'h00) ? 8'h0C : 8'h00);
        end
        clr;
        rc(E_IX, "error clear", 8'hFF, 8'h00);
        rc(S_IX, "status clear", 8'h0C, 8'h00);
        // Data request, acknowledge, late acknowledge
        ev(3);
        rc(S_IX, "data request", 8'h18, 8'h18);
        ack0 = n_ack;
        wr(C_IX, 32'h00000010);
        repeat (3) @(posedge CLOCK);
        chk("ack pulse", 8'hFF, 8'h01, 8'(n_ack - ack0));
        ev(4);
        rc(E_IX, "acked timeout", 8'h04, 8'h00);
        ev(3);
        ev(4);
        rc(E_IX, "late ack", 8'h04, 8'h04);
        // Completion
        ev(1);
        ev(2);
        rc(S_IX, "done set", 8'h01, 8'h01);
        ev(1);
        rc(S_IX, "done cleared", 8'h01, 8'h00);
        ev(2);
        // Abort by early break, cleared by clean break
        ev(0);
        ev(0);
        rc(S_IX, "abort set", 8'h20, 8'h20);
        ev(2);
        ev(0);
        rc(S_IX, "abort clear", 8'h20, 8'h00);
        ev(2);
        // Stop blocks until next break
        wr(C_IX, 32'h00000080);
        repeat (2) @(posedge CLOCK);
        chk("blocked", 8'h01, 8'h01, {7'h00, BLOCKED});
        rc(S_IX, "stop abort", 8'h20, 8'h20);
        ev(3);
        rc(S_IX, "blocked request", 8'h10, 8'h00);
        ev(0);
        chk("unblocked", 8'h01, 8'h00, {7'h00, BLOCKED});
        ev(2);
        // Wakeup sent, then received
        WAKEUP_TX <= 1'b1;
        repeat (3) @(posedge CLOCK);
        rc(S_IX, "wakeup tx", 8'h02, 8'h02);
        WAKEUP_TX <= 1'b0;
        repeat (3) @(posedge CLOCK);
        rc(S_IX, "wakeup off", 8'h02, 8'h00);
        clr;
        ev(10);
        rc(S_IX, "wakeup rx", 8'h0A, 8'h0A);
        // Overlong frame
        clr;
        ev(1);
        repeat (110) @(posedge CLOCK);
        rc(E_IX, "frame timeout", 8'h04, 8'h04);
        // Idle timeout, then sleep drops it
        BUS_ACTIVE <= 1'b0;
        repeat (60) @(posedge CLOCK);
        rc(S_IX, "idle timeout", 8'hC0, 8'h40);
        BUS_SLEEP <= 1'b1;
        repeat (3) @(posedge CLOCK);
        rc(S_IX, "asleep", 8'h40, 8'h00);
        BUS_SLEEP <= 1'b0;
        BUS_ACTIVE <= 1'b1;
        // Master mode: missing response counts, sync error does not
        wr(M_IX, 32'h00000000);
        clr;
        ev(7);
        rc(E_IX, "response timeout", 8'hFF, 8'h04);
        clr;
        ev(5);
        rc(E_IX, "master sync", 8'hFF, 8'h00);
        report_and_stop;
    end
endmodule
